// file: pkg/ieiu_params.svh
`ifndef IEIU_PARAMS_SVH
`define IEIU_PARAMS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define IEIU_NUM_IN      32
`define IEIU_FSET_W      5
`define IEIU_FCNT_W      22
`define IEIU_ADR_W       8

// ----------------------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------------------
`define IEIU_OFF_INPUT   8'h00
`define IEIU_OFF_ENABLE  8'h04
`define IEIU_OFF_EDGE    8'h08
`define IEIU_OFF_STATUS  8'h0C
`define IEIU_OFF_IMASK   8'h10
`define IEIU_OFF_FILTER  8'h14
`define IEIU_OFF_RAW     8'h18

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IEIU_RST_ENABLE  32'h0000_0000
`define IEIU_RST_EDGE    32'h0000_0000
`define IEIU_RST_STATUS  32'h0000_0000
`define IEIU_RST_IMASK   32'hFFFF_FFFF
`define IEIU_RST_FILTER  5'h00
`define IEIU_RST_DATA    32'h0000_0000

// ----------------------------------------------------------------------------
// Filter timing: time = 2^n / 8 MHz, clock 20 MHz, setting range 0..20
// ----------------------------------------------------------------------------
`define IEIU_CLK_KHZ     64'd20000
`define IEIU_FBASE_KHZ   64'd8000
`define IEIU_FSET_MAX    5'h14
`define IEIU_FSET_OFF    5'h00

`endif

// file: pkg/ieiu_pkg.sv
`include "ieiu_params.svh"

package ieiu_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [`IEIU_NUM_IN-1:0] ieiu_word_t;
  typedef logic [`IEIU_ADR_W-1:0]  ieiu_addr_t;
  typedef logic [`IEIU_FSET_W-1:0] ieiu_fset_t;
  typedef logic [`IEIU_FCNT_W-1:0] ieiu_fcnt_t;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    IEIU_BUS_IDLE = 2'b01,
    IEIU_BUS_ACK  = 2'b10
  } ieiu_bus_e;

endpackage : ieiu_pkg

// file: pkg/ieiu_filt_if.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Link between the interrupt core and the input filter
// ----------------------------------------------------------------------------
interface ieiu_filt_if;
  import ieiu_pkg::*;

  ieiu_word_t raw_data;    // Logical input values, before filtering
  ieiu_word_t clean_data;  // Logical input values, after filtering
  ieiu_fset_t setting;     // Filter time setting n

  modport core (output raw_data, output setting, input clean_data);
  modport filt (input raw_data, input setting, output clean_data);
endinterface : ieiu_filt_if

`default_nettype wire

// file: rtl/ieiu_filter.sv
`timescale 1ns/100ps
`default_nettype none

`include "ieiu_params.svh"

module ieiu_filter (
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  rst,
  // Core side
  ieiu_filt_if.filt  fl
);
  import ieiu_pkg::*;

  // --------------------------------------------------------------------------
  // Hold-time filter
  // --------------------------------------------------------------------------
  ieiu_word_t out_q;
  ieiu_word_t out_d;
  ieiu_fcnt_t cnt_q [`IEIU_NUM_IN];
  ieiu_fcnt_t cnt_d [`IEIU_NUM_IN];
  ieiu_fcnt_t limit;

  // Cycles for 2^n / 8 MHz at 20 MHz, rounded up since it is a least time
  function automatic ieiu_fcnt_t hold_cycles(input ieiu_fset_t n);
    logic [63:0] prod;
    prod = (64'd1 << n) * `IEIU_CLK_KHZ;
    hold_cycles = ieiu_fcnt_t'((prod + `IEIU_FBASE_KHZ - 64'd1) / `IEIU_FBASE_KHZ);
  endfunction : hold_cycles

  // Settings above the range are clamped, the slowest filter is the safe choice
  always_comb begin
    limit = hold_cycles((fl.setting > `IEIU_FSET_MAX) ? `IEIU_FSET_MAX : fl.setting);
    for (int i = 0; i < `IEIU_NUM_IN; i++) begin
      out_d[i] = out_q[i];
      cnt_d[i] = '0;
      if (fl.setting == `IEIU_FSET_OFF) begin
        out_d[i] = fl.raw_data[i];                  // Filter off, pass each sample
      end else if (fl.raw_data[i] != out_q[i]) begin
        if (cnt_q[i] + ieiu_fcnt_t'(1) >= limit) begin
          out_d[i] = fl.raw_data[i];                // Level held long enough
        end else begin
          cnt_d[i] = cnt_q[i] + ieiu_fcnt_t'(1);    // Shorter change is dropped
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_q <= `IEIU_RST_DATA;
      for (int i = 0; i < `IEIU_NUM_IN; i++) cnt_q[i] <= '0;
    end else begin
      out_q <= out_d;
      for (int i = 0; i < `IEIU_NUM_IN; i++) cnt_q[i] <= cnt_d[i];
    end
  end

  assign fl.clean_data = out_q;

endmodule : ieiu_filter

`default_nettype wire

// file: rtl/ieiu_top.sv
// How it works
// - Every one of the inputs can request an interrupt on a level change.
// - With filtering on, edges are taken from the filtered input values.
// - Each input has an enable bit; disabled inputs never cause interrupts.
// - After reset all per-input enable bits are disabled.
// - Edge-select zero: logical 0 to 1 (pin high to low) raises interrupt.
// - Edge-select one: logical 1 to 0 (pin low to high) raises interrupt.
// - After reset all edge-select bits are zero.
// - One status bit per input tells software which input caused the request.
// - Reading status or writing ones to it clears status bits and request; host must acknowledge.
// - After reset all status bits are zero.
// - A disabled input never sets its status bit, even on its edge.
// - Pins are active low: low pin is logical one.
// - Filter passes a new level only after it holds for the set time.
// - Thirty-two inputs share one interrupt request output.

`timescale 1ns/100ps
`default_nettype none

`include "ieiu_params.svh"

module ieiu_top (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire ieiu_pkg::ieiu_addr_t wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire ieiu_pkg::ieiu_word_t wb_dat_i,
  output var  ieiu_pkg::ieiu_word_t wb_dat_o,
  output logic                    wb_ack_o,
  // Input pins, active low
  input  wire ieiu_pkg::ieiu_word_t din_n,
  // Interrupt request to the host
  output logic                    irq_o
);
  import ieiu_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Word address match; the two low address bits are ignored
  function automatic logic hit(input ieiu_addr_t adr, input ieiu_addr_t off);
    hit = (adr[`IEIU_ADR_W-1:2] == off[`IEIU_ADR_W-1:2]);
  endfunction : hit

  // Expand byte selects to a bit mask
  function automatic ieiu_word_t sel_mask(input logic [3:0] sel);
    for (int b = 0; b < 4; b++) sel_mask[b*8 +: 8] = {8{sel[b]}};
  endfunction : sel_mask

  // Merge write data into a register under the byte selects
  function automatic ieiu_word_t merge(input ieiu_word_t old, input ieiu_word_t wdat,
                                       input logic [3:0] sel);
    merge = (old & ~sel_mask(sel)) | (wdat & sel_mask(sel));
  endfunction : merge

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ieiu_bus_e  state_q;
  ieiu_bus_e  state_d;
  ieiu_word_t dat_q;
  ieiu_word_t dat_d;
  ieiu_word_t en_q;
  ieiu_word_t en_d;
  ieiu_word_t edge_q;
  ieiu_word_t edge_d;
  ieiu_word_t stat_q;
  ieiu_word_t stat_d;
  ieiu_word_t imask_q;
  ieiu_word_t imask_d;
  ieiu_fset_t fset_q;
  ieiu_fset_t fset_d;
  ieiu_word_t prev_q;
  ieiu_word_t prev_d;
  logic       irq_q;
  logic       irq_d;

  logic       req;
  logic       wr_fire;
  logic       rd_fire;
  ieiu_word_t logic_in;
  ieiu_word_t rise;
  ieiu_word_t fall;
  ieiu_word_t event_v;
  ieiu_word_t clr_v;

  // --------------------------------------------------------------------------
  // Input filter
  // --------------------------------------------------------------------------
  ieiu_filt_if fl_if ();

  // Pins are inverted before the filter so that all logic sees logical values
  assign logic_in       = ~din_n;
  assign fl_if.raw_data = logic_in;
  assign fl_if.setting  = fset_q;

  ieiu_filter u_filter (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fl      (fl_if.filt)
  );

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------

  // A request is taken in IDLE, answered one cycle later with a single ack.
  // The registered ack drops by itself, so back-to-back requests cost a cycle.
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = (state_q == IEIU_BUS_ACK) & req & wb_we_i;
  assign rd_fire = (state_q == IEIU_BUS_ACK) & req & ~wb_we_i;

  always_comb begin
    state_d = state_q;
    dat_d   = `IEIU_RST_DATA;
    unique case (state_q)
      IEIU_BUS_IDLE: begin
        if (req) begin
          state_d = IEIU_BUS_ACK;
          if (!wb_we_i) begin
            if (hit(wb_adr_i, `IEIU_OFF_INPUT)) begin
              dat_d = fl_if.clean_data;
            end else if (hit(wb_adr_i, `IEIU_OFF_ENABLE)) begin
              dat_d = en_q;
            end else if (hit(wb_adr_i, `IEIU_OFF_EDGE)) begin
              dat_d = edge_q;
            end else if (hit(wb_adr_i, `IEIU_OFF_STATUS)) begin
              dat_d = stat_q;             // Source of the pending request
            end else if (hit(wb_adr_i, `IEIU_OFF_IMASK)) begin
              dat_d = imask_q;
            end else if (hit(wb_adr_i, `IEIU_OFF_FILTER)) begin
              dat_d = {{(`IEIU_NUM_IN-`IEIU_FSET_W){1'b0}}, fset_q};
            end else if (hit(wb_adr_i, `IEIU_OFF_RAW)) begin
              dat_d = logic_in;
            end
          end
        end
      end
      IEIU_BUS_ACK: begin
        state_d = IEIU_BUS_IDLE;
        dat_d   = `IEIU_RST_DATA;         // Data stood in the ack cycle; zero once it ends
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------

  // Writes take effect on the acking edge; unmapped or read-only words ignore them
  always_comb begin
    en_d    = en_q;
    edge_d  = edge_q;
    imask_d = imask_q;
    fset_d  = fset_q;
    if (wr_fire) begin
      if (hit(wb_adr_i, `IEIU_OFF_ENABLE)) begin
        en_d = merge(en_q, wb_dat_i, wb_sel_i);
      end
      if (hit(wb_adr_i, `IEIU_OFF_EDGE)) begin
        edge_d = merge(edge_q, wb_dat_i, wb_sel_i);
      end
      if (hit(wb_adr_i, `IEIU_OFF_IMASK)) begin
        imask_d = merge(imask_q, wb_dat_i, wb_sel_i);
      end
      if (hit(wb_adr_i, `IEIU_OFF_FILTER) && wb_sel_i[0]) begin
        fset_d = wb_dat_i[`IEIU_FSET_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Edge detection and status
  // --------------------------------------------------------------------------

  // Edges come from the filter output, never the raw pins
  assign rise = fl_if.clean_data & ~prev_q;
  assign fall = ~fl_if.clean_data & prev_q;

  // Every input is a source; the enable gates the status set itself
  assign event_v = en_q & ((~edge_q & rise) | (edge_q & fall));

  // Clear only the bits that the read returned, so an edge that lands between
  // the sampled read and the acking edge stays pending; a written one clears too
  always_comb begin
    clr_v = '0;
    if (rd_fire && hit(wb_adr_i, `IEIU_OFF_STATUS)) begin
      clr_v = dat_q;                                     // Read acknowledges
    end
    if (wr_fire && hit(wb_adr_i, `IEIU_OFF_STATUS)) begin
      clr_v = clr_v | (wb_dat_i & sel_mask(wb_sel_i));
    end
    prev_d = fl_if.clean_data;
    stat_d = (stat_q & ~clr_v) | event_v;               // Set wins over clear
  end

  // --------------------------------------------------------------------------
  // Interrupt output
  // --------------------------------------------------------------------------

  // All sources fold into one line; it holds until the status is cleared or masked.
  // The mask resets open so the line follows status from power-up.
  always_comb begin
    irq_d = |(stat_d & imask_d);
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= IEIU_BUS_IDLE;
      dat_q   <= `IEIU_RST_DATA;
      en_q    <= `IEIU_RST_ENABLE;
      edge_q  <= `IEIU_RST_EDGE;
      stat_q  <= `IEIU_RST_STATUS;
      imask_q <= `IEIU_RST_IMASK;
      fset_q  <= `IEIU_RST_FILTER;
      prev_q  <= `IEIU_RST_DATA;
      irq_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      dat_q   <= dat_d;
      en_q    <= en_d;
      edge_q  <= edge_d;
      stat_q  <= stat_d;
      imask_q <= imask_d;
      fset_q  <= fset_d;
      prev_q  <= prev_d;
      irq_q   <= irq_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign wb_ack_o = (state_q == IEIU_BUS_ACK);
  assign wb_dat_o = dat_q;
  assign irq_o    = irq_q;

endmodule : ieiu_top

`default_nettype wire

// file: bench/ieiu_pin_src.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Input pin source with board pull-ups
// ----------------------------------------------------------------------------
module ieiu_pin_src (
  // Logical levels and drive enables
  input  wire logic [31:0] lvl,
  input  wire logic [31:0] drv,
  // Pins toward the board
  output logic      [31:0] din_n
);
  // A released pin floats to the pull-up, so it reads as logical zero
  assign din_n = ~(lvl & drv);
endmodule : ieiu_pin_src

`default_nettype wire

// file: bench/ieiu_top_chk.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module ieiu_top_chk (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst,
  // Register bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire ieiu_pkg::ieiu_addr_t wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire ieiu_pkg::ieiu_word_t wb_dat_i,
  input wire ieiu_pkg::ieiu_word_t wb_dat_o,
  input wire logic                 wb_ack_o,
  // Pins and request
  input wire ieiu_pkg::ieiu_word_t din_n,
  input wire logic                 irq_o
);
  import ieiu_pkg::*;

  // Status and mask accesses are the only ways the request may drop
  logic adr_clr;
  logic adr_unm;
  assign adr_clr = (wb_adr_i[7:2] == 6'h03) || (wb_adr_i[7:2] == 6'h04);
  assign adr_unm = wb_adr_i[7:2] > 6'h06;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_unmapped; wb_ack_o && !wb_we_i && adr_unm |-> wb_dat_o == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_hold; irq_o && !wb_ack_o |=> irq_o; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped by itself");
  property p_irq_fall; $fell(irq_o) |-> $past(wb_ack_o && adr_clr); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped without clear");
  property p_rst_quiet; $fell(rst) |-> !irq_o && !wb_ack_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");

  // Main scenarios reached
  c_irq: cover property ($rose(irq_o));
  c_sts: cover property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h03 && wb_dat_o != '0);
  c_clr: cover property ($fell(irq_o));
endmodule : ieiu_top_chk

bind ieiu_top ieiu_top_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .din_n(din_n), .irq_o(irq_o)
);

`default_nettype wire

// file: bench/input_edge_interrupt_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none

`include "ieiu_params.svh"

module input_edge_interrupt_unit_bench;
  import ieiu_pkg::*;

  // One table row: enables, edge selects, levels before and after, status
  typedef struct packed {
    ieiu_word_t en, edg, v0, v1, exp;
  } ieiu_row_s;

  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o;
  logic [3:0] wb_sel_i = 4'hF;
  ieiu_addr_t wb_adr_i = '0;
  ieiu_word_t wb_dat_i = '0, wb_dat_o, din_n, rdata;
  ieiu_word_t lvl = '0, drv = 32'hFFFF_FFFF;
  int         err_total = 0, comparisons = 0;
  ieiu_row_s  rows [7] = '{
    '{32'h1, 32'h0, 32'h0, 32'h1, 32'h1},
    '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0},
    '{32'h1, 32'h1, 32'h1, 32'h0, 32'h1},
    '{32'h1, 32'h1, 32'h0, 32'h1, 32'h0},
    '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0},
    '{32'h8000_0000, 32'h0, 32'h0, 32'h8000_0000, 32'h8000_0000},
    '{32'hFFFF_FFFF, 32'hFFFF_0000, 32'h00FF_00FF, 32'hFF00_FF00, 32'h00FF_FF00}};

  always #25 clk_sys = ~clk_sys;

  ieiu_top u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din_n(din_n), .irq_o(irq_o));
  ieiu_pin_src u_pins (.lvl(lvl), .drv(drv), .din_n(din_n));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task chk(input ieiu_word_t got, input ieiu_word_t exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ack is read just after each rising edge, before the slave's registers move,
  // so the value seen is the one the slave held at that edge
  task bus(input logic we, input ieiu_addr_t adr, input ieiu_word_t dat);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    rdata = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : bus

  task wr(input ieiu_addr_t adr, input ieiu_word_t dat);
    bus(1'b1, adr, dat);
  endtask : wr

  task rd(input ieiu_addr_t adr, input ieiu_word_t exp);
    bus(1'b0, adr, '0);
    chk(rdata, exp);
  endtask : rd

  task chk_irq(input logic exp);
    @(negedge clk_sys);
    chk({31'h0, irq_o}, {31'h0, exp});
  endtask : chk_irq

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // ----------------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------------
  initial begin
    tick(3);
    rst <= 1'b0;
    // Table of edges: status cleared first, then one level step
    foreach (rows[i]) begin
      lvl <= rows[i].v0;
      tick(4);
      wr(`IEIU_OFF_EDGE, rows[i].edg);
      wr(`IEIU_OFF_ENABLE, rows[i].en);
      wr(`IEIU_OFF_STATUS, 32'hFFFF_FFFF);
      lvl <= rows[i].v1;
      tick(4);
      chk_irq(|rows[i].exp);
      rd(`IEIU_OFF_STATUS, rows[i].exp);
      chk_irq(1'b0);
      rd(`IEIU_OFF_STATUS, 32'h0);
      $display("row %0d done", i);
    end
    // Masked request still records status, then clears on a one written
    lvl <= '0;
    tick(4);
    wr(`IEIU_OFF_EDGE, 32'h0);
    wr(`IEIU_OFF_ENABLE, 32'h2);
    wr(`IEIU_OFF_IMASK, 32'h0);
    wr(`IEIU_OFF_STATUS, 32'hFFFF_FFFF);
    lvl <= 32'h2;
    tick(4);
    chk_irq(1'b0);
    wr(`IEIU_OFF_IMASK, 32'h2);
    chk_irq(1'b1);
    wr(`IEIU_OFF_STATUS, 32'h2);
    chk_irq(1'b0);
    wr(`IEIU_OFF_IMASK, 32'hFFFF_FFFF);
    $display("mask test done");
    // Filter at setting 1 needs five steady samples; two are too few
    wr(`IEIU_OFF_FILTER, 32'h1);
    lvl <= '0;
    tick(8);
    wr(`IEIU_OFF_STATUS, 32'hFFFF_FFFF);
    lvl <= 32'h2;
    tick(2);
    lvl <= '0;
    tick(8);
    rd(`IEIU_OFF_STATUS, 32'h0);
    lvl <= 32'h2;
    tick(8);
    rd(`IEIU_OFF_INPUT, 32'h2);
    rd(`IEIU_OFF_STATUS, 32'h2);
    wr(`IEIU_OFF_FILTER, 32'h0);
    rd(8'h1C, 32'h0);
    $display("filter test done");
    // Reset in mid-run with a request pending and a pin held low
    wr(`IEIU_OFF_ENABLE, 32'hFFFF_FFFF);
    wr(`IEIU_OFF_EDGE, 32'hFFFF_FFFF);
    lvl <= '0;
    tick(3);
    chk_irq(1'b1);
    @(posedge clk_sys);
    rst <= 1'b1;
    lvl <= 32'h1;
    tick(3);
    rst <= 1'b0;
    chk_irq(1'b0);
    tick(4);
    rd(`IEIU_OFF_ENABLE, `IEIU_RST_ENABLE);
    rd(`IEIU_OFF_EDGE, `IEIU_RST_EDGE);
    rd(`IEIU_OFF_STATUS, `IEIU_RST_STATUS);
    rd(`IEIU_OFF_IMASK, `IEIU_RST_IMASK);
    rd(`IEIU_OFF_FILTER, {27'h0, `IEIU_RST_FILTER});
    rd(`IEIU_OFF_INPUT, 32'h1);
    rd(`IEIU_OFF_RAW, 32'h1);
    // A released pin goes to its pull-up and reads as logical zero
    drv <= 32'hFFFF_FFFE;
    tick(2);
    rd(`IEIU_OFF_RAW, 32'h0);
    // Byte selects limit a write; the filter word needs the lowest byte
    wb_sel_i <= 4'h1;
    wr(`IEIU_OFF_ENABLE, 32'hFFFF_FFFF);
    rd(`IEIU_OFF_ENABLE, 32'h0000_00FF);
    wb_sel_i <= 4'h2;
    wr(`IEIU_OFF_FILTER, 32'h0000_0003);
    wb_sel_i <= 4'hF;
    rd(`IEIU_OFF_FILTER, 32'h0);
    $display("reset test done");
    end_sim;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #(50 * 5000);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule : input_edge_interrupt_unit_bench

`default_nettype wire
